// *** tgc_pkg.sv ***
package tgc_pkg;
   // ---------------------------------------------------------------
   // Register addresses (byte register address space)
   // ---------------------------------------------------------------
   localparam int unsigned REG_AW = 4;
   localparam int unsigned REG_DW = 8;
   localparam logic [REG_AW-1:0] ADDR_DIN_D_SELECT_A = 4'h5;
   localparam logic [REG_AW-1:0] ADDR_SLOT_GCI_CONTROL = 4'h6;
   localparam logic [REG_AW-1:0] ADDR_MODE_CONFIG_ONE = 4'h7;
   localparam logic [REG_DW-1:0] REG_RESET = 8'h00;
   localparam logic [REG_DW-1:0] READ_HIDDEN = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTL_B1_EN = 7;
   localparam int unsigned CTL_B2_EN = 6;
   localparam int unsigned CTL_D_EN = 5;
   localparam int unsigned CTL_M4_SEL = 4;
   localparam int unsigned CTL_GCI_EN = 3;
   localparam int unsigned MODE_INT_LOOP = 7;
   localparam int unsigned MODE_LINE_CONN = 6;
   localparam int unsigned MODE_STROBE = 5;
   localparam int unsigned MODE_RATE_512K = 4;
   localparam int unsigned MODE_LONG_FRAME = 3;
   localparam int unsigned MODE_CRC_ONCE = 2;
   localparam int unsigned MODE_ROLLOVER = 1;
   localparam int unsigned MODE_TRIPLE = 0;
   localparam int unsigned SELECT_A_W = 3;

   // ---------------------------------------------------------------
   // Frame timing
   // ---------------------------------------------------------------
   localparam int unsigned SLOT_W = 8;
   localparam int unsigned BIT_W = SLOT_W + 1;
   localparam logic [BIT_W-1:0] BIT_CNT_ZERO = 9'h000;
   localparam logic [BIT_W-1:0] BIT_CNT_MAX = 9'h1ff;
   localparam logic [BIT_W-1:0] BIT_CNT_ONE = 9'h001;
   localparam logic [SLOT_W-1:0] LEGACY_D_SLOT = 8'h08;
   localparam logic [SLOT_W-1:0] GCI_CHAN_SPAN = 8'h10;
   localparam logic [SLOT_W-1:0] GCI_D_OFFSET = 8'h08;
   localparam logic [3:0] FS_LONG_MIN = 4'h2;
   localparam logic [3:0] FS_LEN_MAX = 4'hf;
   localparam logic [1:0] DCH_IDLE = 2'b11;

   typedef enum logic [1:0] {
      CRC_IDLE = 2'b00,
      CRC_ARMED = 2'b01,
      CRC_ACTIVE = 2'b10,
      CRC_DONE = 2'b11
   } tgc_crc_state_t;
endpackage : tgc_pkg

// *** tgc_err_counter.sv ***
`timescale 1ns/10ps
module tgc_err_counter #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_clr,
   input wire logic i_inc,
   input wire logic i_rollover,
   output logic [WIDTH-1:0] o_count
);
   logic [WIDTH-1:0] count_ff;
   logic [WIDTH-1:0] nxt_count;
   wire at_top = &count_ff;

   // Wrap to zero or hold at all ones
   assign nxt_count = i_clr ? '0 :
      (!i_inc) ? count_ff :
      (at_top && !i_rollover) ? count_ff : count_ff + 1'b1;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         count_ff <= '0;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign o_count = count_ff;

   AST_CNT_WRAP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (at_top && i_inc && !i_clr) |=>
      (count_ff == ($past(i_rollover) ? '0 : {WIDTH{1'b1}})))
      else $error("error counter wrap or saturate wrong");
endmodule : tgc_err_counter

// *** tgc_slot_regs.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module tgc_slot_regs
   import tgc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_soft_rst,
   input wire logic i_overlay_en,
   input wire logic [tgc_pkg::REG_AW-1:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [tgc_pkg::REG_DW-1:0] i_reg_wdata,
   output logic [tgc_pkg::REG_DW-1:0] o_reg_rdata,
   input wire logic [tgc_pkg::SLOT_W-1:0] i_dout_d_slot,
   input wire logic i_dport_enable,
   input wire logic i_analog_loopback,
   input wire logic i_port_master,
   input wire logic i_nt_mode,
   input wire logic i_interface_mode_pin,
   input wire logic i_port_clock,
   input wire logic i_rx_frame_sync,
   input wire logic i_din,
   input wire logic i_dport_in,
   input wire logic i_status_in_one,
   input wire logic i_status_in_two,
   input wire logic [1:0] i_u_rx_d,
   input wire logic i_crc_corrupt_req,
   input wire logic i_superframe_start,
   input wire logic i_febe_inc,
   input wire logic i_nebe_inc,
   output logic o_dout,
   output logic o_dout_oe,
   output logic o_dport_out,
   output logic o_dport_clock,
   output logic o_bus_driver_enable_n,
   output logic [1:0] o_u_tx_d,
   output logic o_b1_tx_high,
   output logic o_b2_tx_high,
   output logic o_dch_tx_high,
   output logic o_slot_mode,
   output logic o_gci_active,
   output logic o_sf_from_fsync,
   output logic o_m4_from_register,
   output logic o_power_status_one,
   output logic o_power_status_two,
   output logic o_internal_loopback,
   output logic o_line_must_open,
   output logic o_port_rate_512k,
   output logic o_freq_ref_512k,
   output logic o_long_frame,
   output logic o_crc_corrupt,
   output logic o_triple_persist,
   output logic [tgc_pkg::REG_DW-1:0] o_febe_count,
   output logic [tgc_pkg::REG_DW-1:0] o_nebe_count
);
   import tgc_pkg::*;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [REG_DW-1:0] din_slot_ff;
   logic [REG_DW-1:0] ctl_ff;
   logic [REG_DW-1:0] mode_ff;
   logic [REG_DW-1:0] rdata_ff;
   logic [REG_DW-1:0] nxt_rdata;

   wire acc_ok = i_overlay_en;
   wire wr_din = acc_ok && i_reg_wr && (i_reg_addr == ADDR_DIN_D_SELECT_A);
   wire wr_ctl = acc_ok && i_reg_wr && (i_reg_addr == ADDR_SLOT_GCI_CONTROL);
   wire wr_mode = acc_ok && i_reg_wr && (i_reg_addr == ADDR_MODE_CONFIG_ONE);

   assign nxt_rdata = !(acc_ok && i_reg_rd) ? READ_HIDDEN :
      (i_reg_addr == ADDR_DIN_D_SELECT_A) ? din_slot_ff :
      (i_reg_addr == ADDR_SLOT_GCI_CONTROL) ? ctl_ff :
      (i_reg_addr == ADDR_MODE_CONFIG_ONE) ? mode_ff : READ_HIDDEN;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         din_slot_ff <= REG_RESET;
         ctl_ff <= REG_RESET;
         mode_ff <= REG_RESET;
         rdata_ff <= REG_RESET;
      end else if (i_soft_rst) begin
         din_slot_ff <= REG_RESET;
         ctl_ff <= REG_RESET;
         mode_ff <= REG_RESET;
         rdata_ff <= REG_RESET;
      end else begin
         if (wr_din) din_slot_ff <= i_reg_wdata;
         if (wr_ctl) ctl_ff <= i_reg_wdata;
         if (wr_mode) mode_ff <= i_reg_wdata;
         rdata_ff <= nxt_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   localparam int unsigned NSYNC = 7;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   wire [NSYNC-1:0] pins = {i_port_clock, i_rx_frame_sync, i_din,
      i_dport_in, i_status_in_one, i_status_in_two, i_interface_mode_pin};

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
      end
   end

   wire pc_s = sync2_ff[6];
   wire fs_s = sync2_ff[5];
   wire din_s = sync2_ff[4];
   wire dpin_s = sync2_ff[3];
   wire st1_s = sync2_ff[2];
   wire st2_s = sync2_ff[1];
   wire mpin_s = sync2_ff[0];

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   function automatic logic slot_hit(input logic [BIT_W-1:0] cnt,
                                     input logic [SLOT_W-1:0] slot);
      slot_hit = (cnt[BIT_W-1:1] == slot);
   endfunction : slot_hit

   function automatic logic [SLOT_W-1:0] gci_d_slot(
      input logic [SELECT_A_W-1:0] sel);
      logic [SLOT_W-1:0] base;
      base = {{(SLOT_W-SELECT_A_W){1'b0}}, sel};
      gci_d_slot = SLOT_W'(base * GCI_CHAN_SPAN + GCI_D_OFFSET);
   endfunction : gci_d_slot

   wire slot_mode = ctl_ff[CTL_B1_EN] | ctl_ff[CTL_B2_EN] | ctl_ff[CTL_D_EN];
   wire dch_en = ctl_ff[CTL_D_EN];
   wire gci_act = mpin_s && ctl_ff[CTL_GCI_EN];
   wire dport_on = i_dport_enable && mpin_s;
   wire [SLOT_W-1:0] out_slot = gci_act ?
      gci_d_slot(din_slot_ff[SELECT_A_W-1:0]) :
      slot_mode ? i_dout_d_slot : LEGACY_D_SLOT;
   wire [SLOT_W-1:0] in_slot = gci_act ?
      gci_d_slot(din_slot_ff[SELECT_A_W-1:0]) :
      slot_mode ? din_slot_ff : LEGACY_D_SLOT;
   wire dout_ok = !slot_mode || dch_en;
   wire dch_high = slot_mode && !dch_en && !dport_on;

   // ---------------------------------------------------------------
   // Frame and bit counting
   // ---------------------------------------------------------------
   logic pc_prev_ff;
   logic fs_prev_ff;
   logic [BIT_W-1:0] cnt_ff;
   logic [3:0] fs_len_ff;
   logic long_seen_ff;
   logic hold_ff;
   logic [1:0] cap_ff;

   wire pc_rise = pc_s && !pc_prev_ff;
   wire pc_fall = !pc_s && pc_prev_ff;
   wire frame_start = pc_rise && fs_s && !fs_prev_ff;
   wire [BIT_W-1:0] nxt_cnt = frame_start ? BIT_CNT_ZERO :
      (cnt_ff == BIT_CNT_MAX) ? cnt_ff : cnt_ff + BIT_CNT_ONE;
   wire [3:0] nxt_fs_len = frame_start ? 4'h1 :
      (fs_len_ff == FS_LEN_MAX) ? fs_len_ff : fs_len_ff + 4'h1;
   wire in_hit = slot_hit(cnt_ff, in_slot);
   wire out_hit = slot_hit(cnt_ff, out_slot);
   wire tx_src = dport_on ? dpin_s : din_s;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         pc_prev_ff <= 1'b0;
         fs_prev_ff <= 1'b0;
         cnt_ff <= BIT_CNT_MAX;
         fs_len_ff <= 4'h0;
         long_seen_ff <= 1'b0;
         hold_ff <= 1'b0;
         cap_ff <= DCH_IDLE;
      end else begin
         pc_prev_ff <= pc_s;
         if (pc_rise) begin
            fs_prev_ff <= fs_s;
            cnt_ff <= nxt_cnt;
            if (fs_s) fs_len_ff <= nxt_fs_len;
            if (!fs_s && fs_prev_ff) long_seen_ff <= (fs_len_ff >= FS_LONG_MIN);
         end
         if (pc_fall && in_hit) begin
            if (!cnt_ff[0]) hold_ff <= tx_src;
            else cap_ff <= {hold_ff, tx_src};
         end
      end
   end

   // ---------------------------------------------------------------
   // crc corruption control
   // ---------------------------------------------------------------
   tgc_crc_state_t crc_state_ff;
   tgc_crc_state_t nxt_crc_state;
   wire crc_once = mode_ff[MODE_CRC_ONCE];

   always_comb begin
      nxt_crc_state = crc_state_ff;
      case (crc_state_ff)
         CRC_IDLE: if (crc_once && i_crc_corrupt_req) nxt_crc_state = CRC_ARMED;
         CRC_ARMED: if (i_superframe_start) nxt_crc_state = CRC_ACTIVE;
         CRC_ACTIVE: if (i_superframe_start) nxt_crc_state = CRC_DONE;
         CRC_DONE: if (!i_crc_corrupt_req) nxt_crc_state = CRC_IDLE;
         default: nxt_crc_state = CRC_IDLE;
      endcase
      if (!crc_once) nxt_crc_state = CRC_IDLE;
   end

   wire nxt_crc = crc_once ? (nxt_crc_state == CRC_ACTIVE) :
      i_crc_corrupt_req;

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   wire nxt_dout_oe = out_hit && dout_ok;
   wire nxt_dout = cnt_ff[0] ? i_u_rx_d[0] : i_u_rx_d[1];
   wire nxt_drv_n = !(mode_ff[MODE_STROBE] &&
      (nxt_dout_oe || (out_hit && dport_on)));
   wire nxt_ps_pins = !mpin_s && i_nt_mode && !ctl_ff[CTL_M4_SEL];

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         crc_state_ff <= CRC_IDLE;
         o_dout <= 1'b1;
         o_dout_oe <= 1'b0;
         o_dport_out <= 1'b1;
         o_dport_clock <= 1'b0;
         o_bus_driver_enable_n <= 1'b1;
         o_u_tx_d <= DCH_IDLE;
         o_b1_tx_high <= 1'b0;
         o_b2_tx_high <= 1'b0;
         o_dch_tx_high <= 1'b0;
         o_slot_mode <= 1'b0;
         o_gci_active <= 1'b0;
         o_sf_from_fsync <= 1'b0;
         o_m4_from_register <= 1'b0;
         o_power_status_one <= 1'b0;
         o_power_status_two <= 1'b0;
         o_internal_loopback <= 1'b0;
         o_line_must_open <= 1'b0;
         o_port_rate_512k <= 1'b0;
         o_freq_ref_512k <= 1'b0;
         o_long_frame <= 1'b0;
         o_crc_corrupt <= 1'b0;
         o_triple_persist <= 1'b0;
      end else begin
         crc_state_ff <= nxt_crc_state;
         o_dout <= nxt_dout;
         o_dout_oe <= nxt_dout_oe;
         o_dport_out <= dport_on ? nxt_dout : 1'b1;
         o_dport_clock <= dport_on && out_hit && pc_s && !pc_rise;
         o_bus_driver_enable_n <= nxt_drv_n;
         o_u_tx_d <= dch_high ? DCH_IDLE : cap_ff;
         o_b1_tx_high <= slot_mode && !ctl_ff[CTL_B1_EN];
         o_b2_tx_high <= slot_mode && !ctl_ff[CTL_B2_EN];
         o_dch_tx_high <= dch_high;
         o_slot_mode <= slot_mode;
         o_gci_active <= gci_act;
         o_sf_from_fsync <= gci_act && !i_port_master;
         o_m4_from_register <= ctl_ff[CTL_M4_SEL];
         o_power_status_one <= nxt_ps_pins ? st1_s : 1'b0;
         o_power_status_two <= nxt_ps_pins ? st2_s : 1'b0;
         o_internal_loopback <= mode_ff[MODE_INT_LOOP];
         o_line_must_open <= i_analog_loopback && !mode_ff[MODE_LINE_CONN];
         o_port_rate_512k <= mpin_s && mode_ff[MODE_RATE_512K];
         o_freq_ref_512k <= i_nt_mode && !i_port_master &&
            mode_ff[MODE_RATE_512K];
         o_long_frame <= i_port_master ? mode_ff[MODE_LONG_FRAME] :
            long_seen_ff;
         o_crc_corrupt <= nxt_crc;
         o_triple_persist <= mode_ff[MODE_TRIPLE];
      end
   end

   assign o_reg_rdata = rdata_ff;

   // ---------------------------------------------------------------
   // Error counters
   // ---------------------------------------------------------------
   wire [1:0] cnt_inc = {i_febe_inc, i_nebe_inc};
   logic [REG_DW-1:0] err_cnt [2];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_err
         tgc_err_counter #(.WIDTH(REG_DW)) u_cnt (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .i_clr(i_soft_rst),
            .i_inc(cnt_inc[gi]),
            .i_rollover(mode_ff[MODE_ROLLOVER]),
            .o_count(err_cnt[gi])
         );
      end
   endgenerate
   assign o_febe_count = err_cnt[1];
   assign o_nebe_count = err_cnt[0];

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   sequence s_frame_start;
      pc_rise && fs_s && !fs_prev_ff;
   endsequence
   sequence s_slot_off;
      (slot_mode && !dch_en && dport_on) [*2];
   endsequence

   AST_SOFT_CLEAR: assert property (i_soft_rst |=>
      (din_slot_ff == REG_RESET && ctl_ff == REG_RESET && mode_ff == REG_RESET))
      else $error("soft reset left a register set");
   AST_HIDDEN: assert property (i_reg_rd && !i_overlay_en |=>
      o_reg_rdata == READ_HIDDEN) else $error("hidden register readable");
   AST_FRAME_ZERO: assert property (s_frame_start |=> cnt_ff == BIT_CNT_ZERO)
      else $error("bit count not zero at frame start");
   AST_SLOT_MODE: assert property ((|ctl_ff[CTL_B1_EN:CTL_D_EN]) |=>
      o_slot_mode) else $error("slot mode not entered");
   AST_DOUT_FLOAT: assert property (s_slot_off |-> !o_dout_oe)
      else $error("serial output driven with D slot off");
   AST_DCH_HIGH: assert property (dch_high |=> o_u_tx_d == DCH_IDLE)
      else $error("D transmit not forced high");
   AST_STROBE: assert property (o_dout_oe && $past(mode_ff[MODE_STROBE]) |->
      !o_bus_driver_enable_n) else $error("strobe missing during D drive");
   AST_CRC_ONCE: assert property (crc_state_ff == CRC_ACTIVE &&
      i_superframe_start && crc_once |=> !o_crc_corrupt ##1 !o_crc_corrupt)
      else $error("crc corrupted beyond one superframe");
   AST_M4_SRC: assert property ($rose(ctl_ff[CTL_M4_SEL]) |=>
      o_m4_from_register) else $error("M4 source not switched");
   AST_DCLK_RISE: assert property (pc_rise |=> !o_dport_clock)
      else $error("D port clock glitch at port clock rise");
endmodule : tgc_slot_regs

// *** tgc_port_model.sv ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// Line-side codec: free-running port clock, short frame sync
// ---------------------------------------------------------------
module tgc_port_model #(
   parameter int FRAME_BITS = 64
) (
   input wire logic [63:0] i_din_pat,
   input wire logic [63:0] i_dport_pat,
   output logic o_port_clock,
   output logic o_frame_sync,
   output logic o_din,
   output logic o_dport_in,
   output int o_bit_idx
);
   initial begin
      o_port_clock = 1'b0;
      o_frame_sync = 1'b0;
      o_din = 1'b1;
      o_dport_in = 1'b1;
      o_bit_idx = 0;
      forever begin
         for (int b = 0; b < FRAME_BITS; b++) begin
            #20 o_frame_sync = (b == 0);
            #20 o_port_clock = 1'b1;
            o_bit_idx = b;
            o_din = i_din_pat[b];
            o_dport_in = i_dport_pat[b];
            #20 o_frame_sync = 1'b0;
            #20 o_port_clock = 1'b0;
         end
      end
   end
endmodule : tgc_port_model

// *** timeslot_gci_config_regs_bench.sv ***
`timescale 1ns/10ps
module timeslot_gci_config_regs_bench;
   import tgc_pkg::*;
   localparam logic [3:0] A_SLOT = ADDR_DIN_D_SELECT_A;
   localparam logic [3:0] A_CTL = ADDR_SLOT_GCI_CONTROL;
   localparam logic [3:0] A_MODE = ADDR_MODE_CONFIG_ONE;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_soft_rst = 1'b0;
   logic i_overlay_en = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic [3:0] i_reg_addr = 4'h0;
   logic [7:0] i_reg_wdata = 8'h00, i_dout_d_slot = 8'h00;
   logic i_dport_enable = 1'b0, i_analog_loopback = 1'b0;
   logic i_port_master = 1'b0, i_nt_mode = 1'b0;
   logic i_interface_mode_pin = 1'b1, i_status_in_one = 1'b0;
   logic i_status_in_two = 1'b0, i_crc_corrupt_req = 1'b0;
   logic i_superframe_start = 1'b0, i_febe_inc = 1'b0;
   logic i_nebe_inc = 1'b0;
   logic [1:0] i_u_rx_d = 2'b10;
   logic i_port_clock, i_rx_frame_sync, i_din, i_dport_in;
   logic [63:0] din_pat = 64'h0, dport_pat = {32{2'b01}};
   logic [7:0] o_reg_rdata, o_febe_count, o_nebe_count;
   logic [1:0] o_u_tx_d;
   logic o_dout, o_dout_oe, o_dport_out, o_dport_clock;
   logic o_bus_driver_enable_n, o_b1_tx_high, o_b2_tx_high;
   logic o_dch_tx_high, o_slot_mode, o_gci_active, o_sf_from_fsync;
   logic o_m4_from_register, o_power_status_one, o_power_status_two;
   logic o_internal_loopback, o_line_must_open, o_port_rate_512k;
   logic o_freq_ref_512k, o_long_frame, o_crc_corrupt;
   logic o_triple_persist;
   int bit_idx, miscompares = 0, checked = 0, cycles = 0;

   tgc_slot_regs dut_u (
      .i_clk_sys, .i_rst, .i_soft_rst, .i_overlay_en, .i_reg_addr,
      .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_dout_d_slot,
      .i_dport_enable, .i_analog_loopback, .i_port_master, .i_nt_mode,
      .i_interface_mode_pin, .i_port_clock, .i_rx_frame_sync, .i_din,
      .i_dport_in, .i_status_in_one, .i_status_in_two, .i_u_rx_d,
      .i_crc_corrupt_req, .i_superframe_start, .i_febe_inc, .i_nebe_inc,
      .o_dout, .o_dout_oe, .o_dport_out, .o_dport_clock,
      .o_bus_driver_enable_n, .o_u_tx_d, .o_b1_tx_high, .o_b2_tx_high,
      .o_dch_tx_high, .o_slot_mode, .o_gci_active, .o_sf_from_fsync,
      .o_m4_from_register, .o_power_status_one, .o_power_status_two,
      .o_internal_loopback, .o_line_must_open, .o_port_rate_512k,
      .o_freq_ref_512k, .o_long_frame, .o_crc_corrupt,
      .o_triple_persist, .o_febe_count, .o_nebe_count
   );

   tgc_port_model #(.FRAME_BITS(64)) far_u (
      .i_din_pat(din_pat), .i_dport_pat(dport_pat),
      .o_port_clock(i_port_clock), .o_frame_sync(i_rx_frame_sync),
      .o_din(i_din), .o_dport_in(i_dport_in), .o_bit_idx(bit_idx)
   );

   always #5 i_clk_sys = ~i_clk_sys;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      cyc(4);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e,
                     input string nm);
      @(posedge i_clk_sys);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_reg_rd <= 1'b0;
      #1;
      chk(nm, o_reg_rdata, e);
   endtask : rd

   // Waits for the next output slot and checks its bit count
   task automatic slot_at(input int e, input string nm);
      int n;
      n = 0;
      while (o_dout_oe === 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      while (o_dout_oe !== 1'b1 && n < 1300) begin
         cyc(1);
         n++;
      end
      chk(nm, 8'(bit_idx), 8'(e));
   endtask : slot_at

   // Two frames: cycles driving, D port clock rises
   task automatic watch(output int oe_n, output int ck_n);
      logic last;
      oe_n = 0;
      ck_n = 0;
      last = 1'b0;
      repeat (1024) begin
         cyc(1);
         oe_n += int'(o_dout_oe === 1'b1);
         ck_n += int'(o_dport_clock === 1'b1 && last === 1'b0);
         last = o_dport_clock;
      end
   endtask : watch

   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         i_febe_inc <= 1'b1;
         i_nebe_inc <= 1'b1;
         i_superframe_start <= 1'b1;
         @(posedge i_clk_sys);
         i_febe_inc <= 1'b0;
         i_nebe_inc <= 1'b0;
         i_superframe_start <= 1'b0;
      end
      cyc(3);
   endtask : pulse

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      wr(A_CTL, 8'hff);
      chk("hid_mode", o_slot_mode, 8'h0);
      rd(A_CTL, 8'h00, "hid_rd");
      @(posedge i_clk_sys);
      i_overlay_en <= 1'b1;
      rd(A_SLOT, 8'h00, "slot_rst");
      rd(A_CTL, 8'h00, "ctl_rst");
      rd(A_MODE, 8'h00, "mode_rst");
      wr(A_CTL, 8'h07);
      rd(A_CTL, 8'h07, "ctl_rsv");
      chk("rsv_mode", {o_slot_mode, o_gci_active}, 8'h0);
      wr(A_SLOT, 8'hc3);
      rd(A_SLOT, 8'hc3, "slot_rw");
   endtask : t_regs

   task automatic t_slots();
      for (int i = 5; i < 8; i++) begin
         wr(A_CTL, 8'(1 << i));
         chk("slot_vec", {o_slot_mode, o_b1_tx_high, o_b2_tx_high,
             o_dch_tx_high}, {1'b1, i != 7, i != 6, i != 5});
      end
      wr(A_CTL, 8'h00);
      chk("slot_off", {o_slot_mode, o_dch_tx_high}, 8'h0);
   endtask : t_slots

   task automatic t_modes();
      @(posedge i_clk_sys);
      i_analog_loopback <= 1'b1;
      i_port_master <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(A_MODE, 8'(1 << i));
         chk("mode_vec", {o_internal_loopback, o_line_must_open,
             o_port_rate_512k, o_long_frame, o_triple_persist},
             {i == 7, i != 6, i == 4, i == 3, i == 0});
      end
      @(posedge i_clk_sys);
      i_port_master <= 1'b0;
      i_nt_mode <= 1'b1;
      wr(A_MODE, 8'h18);
      chk("slave_vec", {o_freq_ref_512k, o_long_frame}, 8'h2);
   endtask : t_modes

   task automatic t_dout();
      int oe_n;
      int ck_n;
      @(posedge i_clk_sys);
      i_nt_mode <= 1'b0;
      i_dout_d_slot <= 8'd3;
      wr(A_MODE, 8'h20);
      slot_at(2 * LEGACY_D_SLOT, "legacy_slot");
      wr(A_CTL, 8'h20);
      slot_at(6, "d_slot");
      chk("d_first", o_dout, 8'h1);
      chk("strobe", o_bus_driver_enable_n, 8'h0);
      cyc(8);
      chk("d_second", {o_dout_oe, o_dout}, 8'h2);
      watch(oe_n, ck_n);
      chk("d_cycles", 8'(oe_n), 8'd32);
      wr(A_CTL, 8'h80);
      watch(oe_n, ck_n);
      chk("d_off_oe", 8'(oe_n), 8'd0);
      chk("d_off_tx", o_u_tx_d, 8'h3);
   endtask : t_dout

   task automatic t_din();
      int oe_n;
      int ck_n;
      @(posedge i_clk_sys);
      din_pat <= 64'h200;
      wr(A_SLOT, 8'h04);
      wr(A_CTL, 8'h20);
      cyc(1100);
      chk("din_d", o_u_tx_d, 8'h1);
      @(posedge i_clk_sys);
      i_dport_enable <= 1'b1;
      watch(oe_n, ck_n);
      watch(oe_n, ck_n);
      chk("both_oe", 8'(oe_n), 8'd32);
      chk("both_clk", 8'(ck_n), 8'd4);
      chk("dport_tx", o_u_tx_d, 8'h2);
      slot_at(6, "dp_slot");
      cyc(8);
      chk("dport_out", o_dport_out, 8'h0);
      wr(A_CTL, 8'h80);
      watch(oe_n, ck_n);
      chk("port_oe", 8'(oe_n), 8'd0);
      chk("port_clk", 8'(ck_n), 8'd4);
      @(posedge i_clk_sys);
      i_dport_enable <= 1'b0;
   endtask : t_din

   task automatic t_gci();
      wr(A_CTL, 8'h08);
      chk("gci_vec", {o_gci_active, o_sf_from_fsync}, 8'h3);
      wr(A_SLOT, 8'h01);
      slot_at(2 * (1 * 16 + 8), "select_a");
      wr(A_CTL, 8'h18);
      chk("m4_reg", o_m4_from_register, 8'h1);
      @(posedge i_clk_sys);
      i_interface_mode_pin <= 1'b0;
      i_nt_mode <= 1'b1;
      i_status_in_one <= 1'b1;
      wr(A_CTL, 8'h00);
      chk("ps_a", {o_power_status_one, o_power_status_two}, 8'h2);
      @(posedge i_clk_sys);
      i_status_in_one <= 1'b0;
      i_status_in_two <= 1'b1;
      cyc(4);
      chk("ps_b", {o_power_status_one, o_power_status_two}, 8'h1);
      wr(A_CTL, 8'h10);
      chk("ps_reg", {o_power_status_one, o_power_status_two}, 8'h0);
      @(posedge i_clk_sys);
      i_interface_mode_pin <= 1'b1;
      i_nt_mode <= 1'b0;
   endtask : t_gci

   task automatic t_count();
      wr(A_MODE, 8'h00);
      pulse(256);
      chk("febe_sat", o_febe_count, 8'hff);
      chk("nebe_sat", o_nebe_count, 8'hff);
      wr(A_MODE, 8'h02);
      pulse(1);
      chk("febe_wrap", o_febe_count, 8'h00);
      chk("nebe_wrap", o_nebe_count, 8'h00);
      pulse(3);
      @(posedge i_clk_sys);
      i_soft_rst <= 1'b1;
      @(posedge i_clk_sys);
      i_soft_rst <= 1'b0;
      cyc(2);
      chk("cnt_srst", o_febe_count, 8'h00);
      rd(A_MODE, 8'h00, "mode_srst");
      rd(A_SLOT, 8'h00, "slot_srst");
   endtask : t_count

   task automatic t_crc();
      @(posedge i_clk_sys);
      i_crc_corrupt_req <= 1'b1;
      cyc(4);
      chk("crc_lvl", o_crc_corrupt, 8'h1);
      wr(A_MODE, 8'h04);
      @(posedge i_clk_sys);
      i_crc_corrupt_req <= 1'b0;
      cyc(4);
      @(posedge i_clk_sys);
      i_crc_corrupt_req <= 1'b1;
      cyc(4);
      chk("crc_armed", o_crc_corrupt, 8'h0);
      pulse(1);
      chk("crc_once", o_crc_corrupt, 8'h1);
      pulse(1);
      chk("crc_done", o_crc_corrupt, 8'h0);
   endtask : t_crc

   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_regs();
      t_slots();
      t_modes();
      t_dout();
      t_din();
      t_gci();
      t_count();
      t_crc();
      close_out();
   end
endmodule : timeslot_gci_config_regs_bench
